//--- hdl/rifbo_decode.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - thirty-two general registers, 32 bits each
// - 32-bit word, two formats decoded
// - register format: two sources, one destination
// - immediate format: source, destination, 16-bit immediate
// - prefix before immediate widens to 32 bits
// - big-endian, bit 0 most significant
// - word, half and byte accesses supported
// - selectors reach registers zero to thirty-one
// - stream port named by 3-bit field
// - memory accesses aligned to size
// - build parameters only flag units in unitsPresent
// - three operands, two modes, single issue
module rifbo_decode
	import rifbo_pkg::*;
#(
	parameter bit HAS_SHIFTER = 1'b1, // Barrel shifter
	parameter bit HAS_DIVIDER = 1'b1, // Divider
	parameter bit HAS_ICACHE = 1'b0, // Instruction cache
	parameter bit HAS_DCACHE = 1'b0, // Data cache
	parameter bit HAS_DEBUG = 1'b0, // Debug logic
	parameter bit HAS_EXCEPT = 1'b0, // Exception support
	parameter bit HAS_PATTERN = 1'b0, // Pattern compare
	parameter bit HAS_FPU = 1'b0, // Floating point
	parameter bit HAS_MULT = 1'b1 // Multiplier
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic instrValid,
	input wire logic [31:0] instrWord,
	input wire logic wrEn,
	input wire logic [31:0] wrData,
	input wire logic [1:0] memSize,
	input wire logic [1:0] memAddrLow,
	output logic [5:0] opcode,
	output logic immFormat,
	output logic [4:0] destIndex,
	output logic [4:0] src_one_index,
	output logic [4:0] src_two_index,
	output logic [31:0] srcOneData,
	output logic [31:0] srcTwoData,
	output logic [31:0] operandImm,
	output logic immWidened,
	output logic prefixPending,
	output logic [2:0] stream_port_select,
	output logic streamOp,
	output logic [31:0] memLanes,
	output logic [3:0] memLaneEn,
	output logic memMisaligned,
	output logic [8:0] unitsPresent
);
	// ****************************************
	// Field extraction
	// ****************************************
	// Opcode field
	wire logic [5:0] opcNxt = instrWord[OPC_LSB +: OPC_W];
	// Bit 2 of opcode, big-endian numbering
	wire logic fmtNxt = instrWord[FMT_BIT];
	wire logic isPrefix = (opcNxt == OPC_PREFIX);
	// Stream instructions take port number from low bits
	wire logic isStream = (opcNxt == OPC_STREAM_RD) ||
		(opcNxt == OPC_STREAM_WR);
	wire logic [15:0] immField = instrWord[IMM_LSB +: IMM_W];

	// Sign extend the short immediate
	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	// ****************************************
	// Prefix tracking
	// ****************************************
	logic pend_r; // Prefix seen, awaiting next word
	logic [15:0] upper_r; // Held upper half
	wire logic pendNxt = instrValid ? isPrefix : pend_r;
	// Upper half comes only from a prefix
	wire logic [15:0] upperNxt = (instrValid && isPrefix) ? immField :
		upper_r;
	// Widen only for the immediate format right after prefix
	wire logic widen = pend_r && fmtNxt && !isPrefix;
	wire logic [31:0] immNxt = widen ? {upper_r, immField} :
		sext16(immField);

	// Prefix state, one instruction deep
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_r <= 1'b0;
			upper_r <= 16'h0;
		end else begin
			pend_r <= pendNxt;
			upper_r <= upperNxt;
		end
	end

	// ****************************************
	// Decoded fields, registered
	// ****************************************
	// Captured on each valid word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opcode <= 6'h0;
			immFormat <= 1'b0;
			destIndex <= 5'h0;
			src_one_index <= 5'h0;
			src_two_index <= 5'h0;
			operandImm <= RESET_WORD;
			immWidened <= 1'b0;
			stream_port_select <= 3'h0;
			streamOp <= 1'b0;
		end else if (instrValid) begin
			opcode <= opcNxt;
			immFormat <= fmtNxt;
			destIndex <= instrWord[DST_LSB +: IDX_W];
			src_one_index <= instrWord[SRCA_LSB +: IDX_W];
			// Immediate format has no second source
			src_two_index <= fmtNxt ? 5'h0 : instrWord[SRCB_LSB +: IDX_W];
			operandImm <= immNxt;
			immWidened <= widen;
			stream_port_select <= instrWord[PORT_LSB +: PORT_W];
			streamOp <= isStream;
		end
	end
	assign prefixPending = pend_r;

	// ****************************************
	// General register file
	// ****************************************
	// Flip-flop storage; a read returns the value before a same-cycle write
	logic [31:0] gpr_r [REG_N];
	genvar g;
	generate
		for (g = 0; g < REG_N; g++) begin : gGpr
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					gpr_r[g] <= RESET_WORD;
				else if (wrEn && destIndex == g[4:0])
					gpr_r[g] <= wrData;
			end
		end
	endgenerate
	// Operand reads from decoded selectors
	assign srcOneData = gpr_r[src_one_index];
	assign srcTwoData = gpr_r[src_two_index];

	// ****************************************
	// Memory lanes
	// ****************************************
	rifbo_bus_if busLane ();
	assign busLane.size = memSize;
	assign busLane.addrLow = memAddrLow;
	assign busLane.regData = srcTwoData;
	// Lane steering
	rifbo_lane uLane (
		.bus(busLane)
	);
	// Registered so data outputs come from flip-flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			memLanes <= RESET_WORD;
			memLaneEn <= 4'h0;
			memMisaligned <= 1'b0;
		end else begin
			memLanes <= busLane.memData;
			memLaneEn <= busLane.laneEn;
			memMisaligned <= busLane.misaligned;
		end
	end

	// Build options reported as static bits
	assign unitsPresent = {HAS_MULT, HAS_FPU, HAS_PATTERN, HAS_EXCEPT,
		HAS_DEBUG, HAS_DCACHE, HAS_ICACHE, HAS_DIVIDER, HAS_SHIFTER};

	// ****************************************
	// Checks
	// ****************************************
	property p_widen;
		@(posedge clk) disable iff (rst)
		instrValid && isPrefix ##1 instrValid && fmtNxt && !isPrefix
		|=> immWidened && operandImm[31:16] == $past(upper_r);
	endproperty
	a_widen: assert property (p_widen) else $error("no widen");
	property p_lower;
		@(posedge clk) disable iff (rst)
		instrValid && widen |=> operandImm[15:0] == $past(immField);
	endproperty
	a_lower: assert property (p_lower) else $error("lower bad");
	property p_sext;
		@(posedge clk) disable iff (rst)
		instrValid && !pend_r |=> !immWidened &&
			operandImm == sext16($past(immField));
	endproperty
	a_sext: assert property (p_sext) else $error("sext bad");
	property p_srcb;
		@(posedge clk) disable iff (rst)
		instrValid && !fmtNxt |=>
			src_two_index == $past(instrWord[15:11]);
	endproperty
	a_srcb: assert property (p_srcb) else $error("srcb bad");
	property p_port;
		@(posedge clk) disable iff (rst)
		instrValid |=> stream_port_select == $past(instrWord[2:0]);
	endproperty
	a_port: assert property (p_port) else $error("port bad");
	property p_gpr;
		@(posedge clk) disable iff (rst)
		wrEn ##1 !instrValid && !wrEn && src_one_index == $past(destIndex)
		|-> srcOneData == $past(wrData);
	endproperty
	a_gpr: assert property (p_gpr) else $error("gpr bad");
	property p_align;
		@(posedge clk) disable iff (rst)
		memSize == RIF_SZ_WORD && memAddrLow != 2'h0
		|=> memMisaligned && memLaneEn == 4'h0;
	endproperty
	a_align: assert property (p_align) else $error("align bad");
	property p_msb;
		@(posedge clk) disable iff (rst)
		memSize == RIF_SZ_BYTE && memAddrLow == 2'h0
		|=> memLaneEn == 4'h8 && memLanes[31:24] == $past(srcTwoData[7:0]);
	endproperty
	a_msb: assert property (p_msb) else $error("byte lane bad");
	property p_half;
		@(posedge clk) disable iff (rst)
		memSize == RIF_SZ_HALF && memAddrLow == 2'h2
		|=> memLaneEn == 4'h3;
	endproperty
	a_half: assert property (p_half) else $error("half bad");
	c_widen: cover property (@(posedge clk) disable iff (rst) immWidened);
	c_stream: cover property (@(posedge clk) disable iff (rst) streamOp);
	c_mis: cover property (@(posedge clk) disable iff (rst) memMisaligned);
endmodule // rifbo_decode
`default_nettype wire

//--- hdl/rifbo_pkg.sv
package rifbo_pkg;
	// ****************************************
	// Word and field geometry
	// ****************************************
	localparam int WORD_W = 32; // Data and instruction width
	localparam int REG_N = 32; // General registers
	localparam int IDX_W = 5; // Register selector width
	localparam int IMM_W = 16; // Immediate field width
	localparam int PORT_W = 3; // Stream port designator width
	localparam int OPC_W = 6; // Opcode width
	// Field positions, counted from the lsb of the word
	localparam int OPC_LSB = 26;
	localparam int DST_LSB = 21;
	localparam int SRCA_LSB = 16;
	localparam int SRCB_LSB = 11;
	localparam int IMM_LSB = 0;
	localparam int PORT_LSB = 0;
	// Opcode bit that marks the immediate format
	localparam int FMT_BIT = 29;
	// Prefix opcode
	localparam logic [5:0] OPC_PREFIX = 6'h2c;
	// Stream opcodes
	localparam logic [5:0] OPC_STREAM_RD = 6'h1b;
	localparam logic [5:0] OPC_STREAM_WR = 6'h3b;
	// Access sizes
	typedef enum logic [1:0] {
		RIF_SZ_BYTE = 2'h0,
		RIF_SZ_HALF = 2'h1,
		RIF_SZ_WORD = 2'h2
	} rifbo_size_t;
	localparam logic [31:0] RESET_WORD = 32'h0;
endpackage

//--- hdl/rifbo_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Load/store lane bundle
// ****************************************
interface rifbo_bus_if;
	logic [1:0] size; // Access size
	logic [1:0] addrLow; // Byte offset
	logic [31:0] regData; // Register side value
	logic [31:0] memData; // Memory side lanes
	logic [3:0] laneEn; // Byte enables, lane 3 at address n
	logic misaligned; // Address not size aligned
	modport user (output size, addrLow, regData,
		input memData, laneEn, misaligned);
	modport lane (input size, addrLow, regData,
		output memData, laneEn, misaligned);
endinterface
`default_nettype wire

//--- hdl/rifbo_lane.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Big-endian byte lane steering
// ****************************************
module rifbo_lane
	import rifbo_pkg::*;
(
	rifbo_bus_if.lane bus
);
	wire logic isHalf = (bus.size == RIF_SZ_HALF); // Half access
	wire logic isWord = (bus.size == RIF_SZ_WORD); // Word access
	// Lowest address takes the most significant byte
	wire logic [31:0] halfLanes = bus.addrLow[1] ?
		{16'h0, bus.regData[15:0]} : {bus.regData[15:0], 16'h0};
	wire logic [7:0] b = bus.regData[7:0];
	wire logic [31:0] byteLanes = (bus.addrLow == 2'h0) ? {b, 24'h0} :
		(bus.addrLow == 2'h1) ? {8'h0, b, 16'h0} :
		(bus.addrLow == 2'h2) ? {16'h0, b, 8'h0} : {24'h0, b};
	assign bus.memData = isWord ? bus.regData :
		(isHalf ? halfLanes : byteLanes);
	// Enables; lane 3 is address n
	wire logic [3:0] byteEn = 4'h8 >> bus.addrLow;
	wire logic [3:0] halfEn = bus.addrLow[1] ? 4'h3 : 4'hc;
	assign bus.laneEn = bus.misaligned ? 4'h0 :
		(isWord ? 4'hf : (isHalf ? halfEn : byteEn));
	// Size alignment check
	assign bus.misaligned = (isWord && bus.addrLow != 2'h0) ||
		(isHalf && bus.addrLow[0]);
endmodule // rifbo_lane
`default_nettype wire

//--- test/rifbo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Byte memory behind the store lanes
// ****************************************
module rifbo_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic store, // Write strobe from the bench
	input wire logic [31:0] memLanes, // Lane data
	input wire logic [3:0] memLaneEn, // Bit 3 is address n
	output logic [31:0] image // Bytes n..n+3, n in [31:24]
);
	// Lane k lands at n+3-k; lanes not enabled keep old bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			image <= 32'h0;
		end else if (store) begin
			for (int k = 0; k < 4; k++) begin
				if (memLaneEn[k]) begin
					image[8*k +: 8] <= memLanes[8*k +: 8];
				end
			end
		end
	end
endmodule // rifbo_mem_model
`default_nettype wire

//--- test/rifbo_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module rifbo_decode_test
	import rifbo_pkg::*;
;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk, rst, instrValid, wrEn, store;
	logic [31:0] instrWord, wrData, image, expImg;
	logic [1:0] memSize, memAddrLow;
	logic [5:0] opcode;
	logic immFormat, immWidened, prefixPending, streamOp, memMisaligned;
	logic [4:0] destIndex, src_one_index, src_two_index;
	logic [31:0] srcOneData, srcTwoData, operandImm, memLanes;
	logic [2:0] stream_port_select;
	logic [3:0] memLaneEn;
	logic [8:0] unitsPresent;
	int n_fail, n_checks;
	// Shifter off, FPU on, so the unit mask is not the default
	rifbo_decode #(.HAS_SHIFTER(1'b0), .HAS_FPU(1'b1)) u_rifbo_decode (
		.clk, .rst, .instrValid, .instrWord, .wrEn, .wrData, .memSize,
		.memAddrLow, .opcode, .immFormat, .destIndex, .src_one_index,
		.src_two_index, .srcOneData, .srcTwoData, .operandImm,
		.immWidened, .prefixPending, .stream_port_select, .streamOp,
		.memLanes, .memLaneEn, .memMisaligned, .unitsPresent);
	rifbo_mem_model u_rifbo_mem_model (.clk, .rst, .store, .memLanes,
		.memLaneEn, .image);
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Drives one word; the next edge takes it
	task automatic issue(input logic [31:0] w);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
	endtask
	// Ends a burst; outputs are settled on return
	task automatic settle;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
	endtask
	// Write lands in the register named by the decoded destination
	// First source names it too, so the read-back check has work to do
	task automatic wr(input logic [4:0] r, input logic [31:0] d);
		issue({6'h00, r, r, 16'h0});
		settle();
		@(posedge clk);
		wrEn <= 1'b1;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		// Neighbour register is never written, so it must read zero
		for (int r = 1; r < 32; r += 15) begin
			wr(r[4:0], 32'h5a000000 + r);
			issue({6'h00, 5'd2, r[4:0], 5'(r - 1), 11'h0});
			settle();
			chk("srcOneIdx", 32'(r), 32'(src_one_index));
			chk("srcTwoIdx", 32'(r - 1), 32'(src_two_index));
			chk("srcOneData", 32'h5a000000 + r, srcOneData);
			chk("srcTwoData", 32'h0, srcTwoData);
			chk("destIdx", 32'h2, 32'(destIndex));
			chk("immFormat", 32'h0, 32'(immFormat));
		end
		$display("t_regs done");
	endtask
	task automatic t_imm;
		issue({6'h08, 5'd3, 5'd7, 16'h8001});
		settle();
		chk("immFormat", 32'h1, 32'(immFormat));
		chk("opcode", 32'h08, 32'(opcode));
		chk("srcTwoIdx", 32'h0, 32'(src_two_index));
		chk("destIdx", 32'h3, 32'(destIndex));
		chk("srcOneIdx", 32'h7, 32'(src_one_index));
		chk("operandImm", 32'hffff8001, operandImm);
		chk("immWidened", 32'h0, 32'(immWidened));
		$display("t_imm done");
	endtask
	task automatic t_prefix;
		// Idle cycle between prefix and user must not drop it
		issue({6'h2c, 10'h0, 16'h1234});
		settle();
		chk("prefixPending", 32'h1, 32'(prefixPending));
		issue({6'h08, 5'd1, 5'd2, 16'h8005});
		settle();
		chk("operandImm", 32'h12348005, operandImm);
		chk("immWidened", 32'h1, 32'(immWidened));
		chk("prefixPending", 32'h0, 32'(prefixPending));
		// Back to back: prefix, user, then a plain immediate
		issue({6'h2c, 10'h0, 16'hbeef});
		issue({6'h0c, 5'd1, 5'd2, 16'h0042});
		issue({6'h08, 5'd1, 5'd2, 16'h7fff});
		#1;
		chk("operandImm", 32'hbeef0042, operandImm);
		settle();
		chk("operandImm", 32'h00007fff, operandImm);
		chk("immWidened", 32'h0, 32'(immWidened));
		$display("t_prefix done");
	endtask
	task automatic t_stream;
		// Both stream opcodes, every port number
		for (int p = 0; p < 8; p++) begin
			issue({p[0] ? 6'h3b : 6'h1b, 5'd4, 18'h0, 3'(p)});
			settle();
			chk("portSel", 32'(p), 32'(stream_port_select));
			chk("streamOp", 32'h1, 32'(streamOp));
		end
		issue({6'h08, 26'h7});
		settle();
		chk("streamOp", 32'h0, 32'(streamOp));
		$display("t_stream done");
	endtask
	task automatic t_lanes;
		logic mis;
		wr(5'd5, 32'ha1b2c3d4);
		issue({6'h00, 10'h0, 5'd5, 11'h0});
		settle();
		expImg = 32'h0;
		// Every size at every offset; misaligned stores must not land
		for (int sz = 0; sz < 3; sz++) begin
			for (int off = 0; off < 4; off++) begin
				mis = (sz == 2 && off != 0) || (sz == 1 && off % 2 == 1);
				@(posedge clk);
				memSize <= 2'(sz);
				memAddrLow <= 2'(off);
				@(posedge clk);
				store <= 1'b1;
				#1;
				chk("misaligned", 32'(mis), 32'(memMisaligned));
				chk("laneEn", mis ? 32'h0 : sz == 2 ? 32'hf :
					32'((sz == 1 ? 4'hc : 4'h8) >> off), 32'(memLaneEn));
				// Lowest address is the top lane, whatever the alignment
				chk("memLanes", sz == 2 ? 32'ha1b2c3d4 : sz == 1 ?
					(off < 2 ? 32'hc3d40000 : 32'h0000c3d4) :
					32'hd4 << 8 * (3 - off), memLanes);
				@(posedge clk);
				store <= 1'b0;
				#1;
				if (!mis && sz == 0) expImg[31 - 8*off -: 8] = 8'hd4;
				if (!mis && sz == 1) expImg[31 - 8*off -: 16] = 16'hc3d4;
				if (!mis && sz == 2) expImg = 32'ha1b2c3d4;
				chk("memImage", expImg, image);
			end
		end
		$display("t_lanes done");
	endtask
	// ****************************************
	// Clock, reset, sequence, watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst, instrValid, wrEn, store} = 4'hf;
		{instrWord, wrData, memSize, memAddrLow} = 68'h0;
		{instrValid, wrEn, store} = 3'h0;
		n_fail = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk("units", 32'h182, 32'(unitsPresent));
		t_regs();
		t_imm();
		t_prefix();
		t_stream();
		t_lanes();
		test_done();
	end
	// Whole run is under a hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		test_done();
	end
endmodule // rifbo_decode_test
`default_nettype wire
